/* common/uart_cfg.svh */
// Purpose: Timing and framing constants of the serial transceiver.
// Assumes: One oversample tick per sample period, 16 per bit.
// Notes: Definitions only.
`ifndef UART_CFG_SVH
`define UART_CFG_SVH

`define OVS_LAST 4'hF
`define OVS_HALF 4'h7
`define CNT_ZERO 4'h0
`define BIT_ZERO 3'h0
`define BITS_8_LAST 3'h7
`define BITS_7_LAST 3'h6
`define BYTE_ZERO 8'h00
`define LINE_IDLE 1'b1
`define LINE_START 1'b0

`endif

/* common/uart_pkg.sv */
// Purpose: State types of the serial transceiver's transmitter and receiver.
// Assumes: Nothing beyond the cfg header.
// Notes: State codes are binary and fixed.
package uart_pkg;

   typedef enum logic [2:0] {
      TX_IDLE = 3'h0,
      TX_START = 3'h1,
      TX_DATA = 3'h2,
      TX_PARITY = 3'h3,
      TX_STOP = 3'h4
   } tx_state_t;

   typedef enum logic [2:0] {
      RX_IDLE = 3'h0,
      RX_START = 3'h1,
      RX_DATA = 3'h2,
      RX_PARITY = 3'h3,
      RX_STOP = 3'h4
   } rx_state_t;

endpackage : uart_pkg

/* hw/async_serial_transceiver.sv */
// Purpose: Full-duplex asynchronous serial transceiver, one holding word per direction.
// Assumes: Oversample ticks are one-cycle pulses at sixteen per bit; inputs synchronous.
// Notes: Config bits are plain ports held by the surrounding register file.
// Contract
// RQ1: Reception runs when either receive-enable bit is one.
// RQ2: Characters carry seven or eight data bits per word-length bit.
// RQ3: With parity enabled, add parity on transmit, check it on receive.
// RQ4: Receive and transmit lines each invert by their own bit.
// RQ5: Echo mode drives transmit from receive line xor transmit-invert.
// RQ6: Characters go out only while transmit enable is set; the code gates the load only, so a started character finishes.
// RQ7: Writing the holding register sets the transmit-full flag.
// RQ8: After a character ends, load holding into shifter, clear full.
// RQ9: Transmit interrupt pulses when transmit-full falls.
// RQ10: Transmit-busy is high while a character shifts out.
// RQ11: Data bits go least significant first.
// RQ12: Software writes the holding register only while full reads zero.
// RQ13: Receive-busy sets on start-bit detection.
// RQ14: At stop bit, move data, set receive-full, pulse receive interrupt.
// RQ15: Reading data clears full; unread data overwritten sets overrun.
// RQ16: Overrun stays until any write to the receive status register.
// RQ17: Start-error flag updates when data moves to the data register.
// RQ18: Parity-error flag set on mismatch, updated at data transfer.
// RQ19: Frame-error flag set when no valid stop bit is seen.
// RQ20: Software reads received data before the next character completes.
// RQ21: Parity mode zero means odd, one means even.
// RQ22: Word-length one means eight bits, zero seven; eight after reset.
// RQ23: Clock-select zero uses RC source ticks, one crystal ticks.
// RQ24: Frame is low start, data, optional parity, one high stop.
// RQ25: Receiver oversamples and takes each bit near mid-period.
`timescale 1ns/10ps
`include "uart_cfg.svh"

module async_serial_transceiver
   import uart_pkg::*;
(
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic rc_tick,
   input wire logic xtal_tick,
   input wire logic clock_source_select,
   input wire logic tx_enable,
   input wire logic rx_enable_a,
   input wire logic rx_enable_b,
   input wire logic word_length_sel,
   input wire logic parity_enable,
   input wire logic parity_mode,
   input wire logic rx_invert,
   input wire logic tx_invert,
   input wire logic echo_mode,
   input wire logic tx_write,
   input wire logic [7:0] tx_write_data,
   input wire logic rx_read,
   input wire logic rx_status_write,
   input wire logic rx_pin,
   output logic tx_pin,
   output logic [7:0] tx_holding_reg,
   output logic tx_full_flag,
   output logic tx_busy_flag,
   output logic tx_irq,
   output logic [7:0] rx_data_reg,
   output logic rx_full_flag,
   output logic rx_busy_flag,
   output logic overrun_error_flag,
   output logic start_error_flag,
   output logic parity_error_flag,
   output logic frame_error_flag,
   output logic rx_irq
);

   // Parity bit: even gives xor of data, odd its complement
   function automatic logic parity_of(input logic [7:0] data, input logic wl, input logic mode);
      logic [7:0] masked;
      masked = wl ? data : {1'b0, data[6:0]};
      // RQ21: odd or even sense
      parity_of = (^masked) ^ ~mode;
   endfunction : parity_of

   // Index of the last data bit for the chosen word length
   function automatic logic [2:0] last_bit(input logic wl);
      // RQ22: one gives eight bits
      last_bit = wl ? `BITS_8_LAST : `BITS_7_LAST;
   endfunction : last_bit

   logic tick;
   logic rx_line;
   logic rx_on;

   // RQ23: tick source select
   assign tick = clock_source_select ? xtal_tick : rc_tick;
   // RQ4: receive inversion
   assign rx_line = rx_pin ^ rx_invert;
   // RQ1: either enable bit
   assign rx_on = rx_enable_a | rx_enable_b;

   // Transmitter
   tx_state_t tx_state_q;
   logic [3:0] tx_cnt_q;
   logic [2:0] tx_bit_q;
   logic [7:0] tx_shift_q;
   logic tx_line_q;
   logic tx_load;
   logic tx_bit_end;

   // RQ6: load only when enabled
   // RQ8: load after previous character
   assign tx_load = (tx_state_q == TX_IDLE) && tx_full_flag && tx_enable;
   assign tx_bit_end = tick && (tx_cnt_q == `OVS_LAST);
   // RQ10: busy while shifting
   assign tx_busy_flag = (tx_state_q != TX_IDLE);

   // RQ7: write sets full; a write in the load cycle keeps it set
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         tx_full_flag <= 1'b0;
      end else if (tx_write) begin
         tx_full_flag <= 1'b1;
      end else if (tx_load) begin
         tx_full_flag <= 1'b0;
      end
   end

   // Overwriting a pending word loses it, as software is told
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         tx_holding_reg <= `BYTE_ZERO;
      end else if (tx_write) begin
         tx_holding_reg <= tx_write_data;
      end
   end

   // RQ9: pulse on full falling
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         tx_irq <= 1'b0;
      end else begin
         tx_irq <= tx_load && !tx_write;
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         tx_cnt_q <= `CNT_ZERO;
      end else if (tx_load) begin
         tx_cnt_q <= `CNT_ZERO;
      end else if (tick && tx_state_q != TX_IDLE) begin
         tx_cnt_q <= tx_cnt_q + 4'h1;
      end
   end

   // RQ24: start, data, parity, stop
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         tx_state_q <= TX_IDLE;
         tx_bit_q <= `BIT_ZERO;
         tx_shift_q <= `BYTE_ZERO;
         tx_line_q <= `LINE_IDLE;
      end else begin
         case (tx_state_q)
            TX_IDLE: begin
               if (tx_load) begin
                  tx_shift_q <= tx_holding_reg;
                  tx_line_q <= `LINE_START;
                  tx_state_q <= TX_START;
               end
            end
            TX_START: begin
               if (tx_bit_end) begin
                  tx_bit_q <= `BIT_ZERO;
                  tx_line_q <= tx_shift_q[0];
                  tx_state_q <= TX_DATA;
               end
            end
            TX_DATA: begin
               if (tx_bit_end) begin
                  // RQ2: word length
                  if (tx_bit_q == last_bit(word_length_sel)) begin
                     if (parity_enable) begin
                        // RQ3: parity appended
                        tx_line_q <= parity_of(tx_shift_q, word_length_sel, parity_mode);
                        tx_state_q <= TX_PARITY;
                     end else begin
                        tx_line_q <= `LINE_IDLE;
                        tx_state_q <= TX_STOP;
                     end
                  end else begin
                     tx_bit_q <= tx_bit_q + 3'h1;
                     // RQ11: LSB first
                     tx_line_q <= tx_shift_q[tx_bit_q + 3'h1];
                  end
               end
            end
            TX_PARITY: begin
               if (tx_bit_end) begin
                  tx_line_q <= `LINE_IDLE;
                  tx_state_q <= TX_STOP;
               end
            end
            TX_STOP: begin
               if (tx_bit_end) begin
                  tx_state_q <= TX_IDLE;
               end
            end
            default: begin
               tx_state_q <= TX_IDLE;
               tx_line_q <= `LINE_IDLE;
            end
         endcase
      end
   end

   // RQ5: echo path
   // RQ4: transmit inversion
   assign tx_pin = echo_mode ? (rx_pin ^ tx_invert) : (tx_line_q ^ tx_invert);

   // Receiver
   rx_state_t rx_state_q;
   logic [3:0] rx_cnt_q;
   logic [2:0] rx_bit_q;
   logic [7:0] rx_shift_q;
   logic rx_prev_q;
   logic rx_par_q;
   logic start_pend_q;
   logic rx_fall;
   logic rx_mid;
   logic rx_xfer;

   assign rx_fall = rx_on && rx_prev_q && !rx_line;
   // RQ25: mid-bit sampling
   assign rx_mid = tick && (rx_cnt_q == ((rx_state_q == RX_START) ? `OVS_HALF : `OVS_LAST));
   assign rx_xfer = (rx_state_q == RX_STOP) && rx_mid;
   // RQ13: busy from start edge
   assign rx_busy_flag = (rx_state_q != RX_IDLE);

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         rx_prev_q <= `LINE_IDLE;
      end else begin
         rx_prev_q <= rx_line;
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         rx_cnt_q <= `CNT_ZERO;
      end else if (rx_state_q == RX_IDLE || rx_mid) begin
         rx_cnt_q <= `CNT_ZERO;
      end else if (tick) begin
         rx_cnt_q <= rx_cnt_q + 4'h1;
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         rx_state_q <= RX_IDLE;
         rx_bit_q <= `BIT_ZERO;
         rx_shift_q <= `BYTE_ZERO;
         rx_par_q <= 1'b0;
      end else if (!rx_on) begin
         rx_state_q <= RX_IDLE;
      end else begin
         case (rx_state_q)
            RX_IDLE: begin
               if (rx_fall) begin
                  rx_state_q <= RX_START;
               end
            end
            RX_START: begin
               // A start bit gone high by mid-period is dropped
               if (rx_mid) begin
                  rx_bit_q <= `BIT_ZERO;
                  rx_shift_q <= `BYTE_ZERO;
                  rx_state_q <= (rx_line == `LINE_START) ? RX_DATA : RX_IDLE;
               end
            end
            RX_DATA: begin
               if (rx_mid) begin
                  // RQ11: LSB first
                  rx_shift_q[rx_bit_q] <= rx_line;
                  // RQ2: word length
                  if (rx_bit_q == last_bit(word_length_sel)) begin
                     rx_state_q <= parity_enable ? RX_PARITY : RX_STOP;
                  end else begin
                     rx_bit_q <= rx_bit_q + 3'h1;
                  end
               end
            end
            RX_PARITY: begin
               if (rx_mid) begin
                  rx_par_q <= rx_line;
                  rx_state_q <= RX_STOP;
               end
            end
            RX_STOP: begin
               if (rx_mid) begin
                  rx_state_q <= RX_IDLE;
               end
            end
            default: begin
               rx_state_q <= RX_IDLE;
            end
         endcase
      end
   end

   // Failed start is held until the next transfer reports it
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         start_pend_q <= 1'b0;
      end else if (rx_state_q == RX_START && rx_mid && rx_line != `LINE_START) begin
         start_pend_q <= 1'b1;
      end else if (rx_xfer) begin
         start_pend_q <= 1'b0;
      end
   end

   // RQ14: transfer and interrupt together
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         rx_data_reg <= `BYTE_ZERO;
         rx_irq <= 1'b0;
      end else begin
         rx_irq <= rx_xfer;
         if (rx_xfer) begin
            rx_data_reg <= rx_shift_q;
         end
      end
   end

   // RQ15: read clears, transfer wins
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         rx_full_flag <= 1'b0;
      end else if (rx_xfer) begin
         rx_full_flag <= 1'b1;
      end else if (rx_read) begin
         rx_full_flag <= 1'b0;
      end
   end

   // RQ16: overrun sticky until status write
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         overrun_error_flag <= 1'b0;
      end else if (rx_xfer && rx_full_flag && !rx_read) begin
         overrun_error_flag <= 1'b1;
      end else if (rx_status_write) begin
         overrun_error_flag <= 1'b0;
      end
   end

   // RQ17: start error at transfer
   // RQ18: parity check at transfer
   // RQ19: stop bit must be high
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         start_error_flag <= 1'b0;
         parity_error_flag <= 1'b0;
         frame_error_flag <= 1'b0;
      end else if (rx_xfer) begin
         start_error_flag <= start_pend_q;
         parity_error_flag <= parity_enable &&
            (rx_par_q != parity_of(rx_shift_q, word_length_sel, parity_mode));
         frame_error_flag <= (rx_line != `LINE_IDLE);
      end
   end

endmodule : async_serial_transceiver

/* tb/serial_monitor.sv */
// Purpose: Port checks for the serial transceiver.
// Assumes: Inputs change just after the rising edge.
// Notes: Bound to every transceiver instance.
`timescale 1ns/10ps
module serial_monitor (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic rx_enable_a,
   input wire logic rx_enable_b,
   input wire logic rx_busy_flag,
   input wire logic echo_mode,
   input wire logic rx_pin,
   input wire logic rx_invert,
   input wire logic tx_pin,
   input wire logic tx_invert,
   input wire logic tx_enable,
   input wire logic tx_write,
   input wire logic [7:0] tx_write_data,
   input wire logic [7:0] tx_holding_reg,
   input wire logic tx_full_flag,
   input wire logic tx_busy_flag,
   input wire logic tx_irq,
   input wire logic rx_irq,
   input wire logic rx_full_flag,
   input wire logic rx_read,
   input wire logic rx_status_write,
   input wire logic overrun_error_flag,
   input wire logic start_error_flag,
   input wire logic parity_error_flag,
   input wire logic frame_error_flag
);
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   // Load step: busy and interrupt up with the fall, interrupt gone next cycle
   sequence load_s;
      tx_busy_flag && tx_irq ##1 !tx_irq;
   endsequence
   rx_off_idle_a: assert property (!rx_enable_a && !rx_enable_b |=> !rx_busy_flag)
      else $error("receiver busy while disabled");
   echo_path_a: assert property (echo_mode |-> tx_pin == (rx_pin ^ tx_invert))
      else $error("echo output wrong");
   tx_gate_a: assert property (!tx_enable |=> !$rose(tx_busy_flag))
      else $error("transmit started while disabled");
   tx_write_full_a: assert property (tx_write |=> tx_full_flag && tx_holding_reg == $past(tx_write_data))
      else $error("holding write not taken");
   tx_load_irq_a: assert property ($fell(tx_full_flag) |-> load_s)
      else $error("load step wrong");
   tx_start_low_a: assert property ($rose(tx_busy_flag) && !echo_mode |-> tx_pin == tx_invert)
      else $error("start bit not low");
   overrun_set_a: assert property (rx_irq && $past(rx_full_flag) && !$past(rx_read) |-> overrun_error_flag)
      else $error("overrun not flagged");
   overrun_hold_a: assert property (overrun_error_flag && !rx_status_write |=> overrun_error_flag)
      else $error("overrun dropped early");
   rx_err_stable_a: assert property (!rx_irq |-> $stable(parity_error_flag) && $stable(frame_error_flag)
      && $stable(start_error_flag))
      else $error("error flag moved outside transfer");
   tx_irq_fall_a: assert property (tx_irq |-> $fell(tx_full_flag))
      else $error("transmit interrupt without load");
   rx_busy_set_a: assert property ((rx_enable_a || rx_enable_b) && !rx_busy_flag && $fell(rx_pin ^ rx_invert)
      |=> rx_busy_flag)
      else $error("receiver not busy after start edge");
endmodule : serial_monitor

bind async_serial_transceiver serial_monitor i_mon (.clock, .sys_rst, .rx_enable_a, .rx_enable_b, .rx_busy_flag,
   .echo_mode, .rx_pin, .rx_invert, .tx_pin, .tx_invert, .tx_enable, .tx_write, .tx_write_data, .tx_holding_reg,
   .tx_full_flag,
   .tx_busy_flag, .tx_irq, .rx_irq, .rx_full_flag, .rx_read, .rx_status_write, .overrun_error_flag,
   .start_error_flag, .parity_error_flag, .frame_error_flag);

/* tb/remote_station.sv */
// Purpose: Remote serial station on the far side of the line pair.
// Assumes: Bit length in clocks set by the bench.
// Notes: Line idles high before inversion.
`timescale 1ns/10ps
module remote_station (
   input wire logic clock,
   input wire logic tx_line,
   input wire logic line_inv,
   input wire logic [7:0] bit_len,
   output logic rx_line
);
   logic lvl_q = 1'b1;
   assign rx_line = lvl_q ^ line_inv;
   task automatic hold(input int k);
      repeat (k) @(posedge clock);
      #1;
   endtask : hold
   // low start, lsb first, stop last
   task automatic send(input logic [9:0] bits, input int n);
      lvl_q = 1'b0;
      hold(bit_len);
      for (int i = 0; i <= n; i++) begin
         lvl_q = bits[i];
         hold(bit_len);
      end
      lvl_q = 1'b1;
   endtask : send
   // Short low pulse, back high before mid start
   task automatic glitch();
      lvl_q = 1'b0;
      hold(bit_len / 4);
      lvl_q = 1'b1;
      hold(bit_len * 2);
   endtask : glitch
   task automatic recv(input int n, output logic [9:0] bits);
      int k;
      bits = '0;
      for (k = 0; k < 4000 && (tx_line ^ line_inv) !== 1'b0; k++) hold(1);
      hold(bit_len / 2);
      for (int i = 0; i <= n; i++) begin
         hold(bit_len);
         bits[i] = tx_line ^ line_inv;
      end
   endtask : recv
endmodule : remote_station

/* tb/tb.sv */
// Purpose: Self-checking bench for the serial transceiver.
// Assumes: Ticks every 2 (rc) or 3 (crystal) clocks.
// Notes: Remote station drives and decodes the line.
`timescale 1ns/10ps
module tb;
   logic clock, sys_rst, rc_tick, xtal_tick, clock_source_select, tx_enable, rx_enable_a, rx_enable_b;
   logic word_length_sel, parity_enable, parity_mode, rx_invert, tx_invert, echo_mode, tx_write, rx_read;
   logic rx_status_write, rx_pin, tx_pin, tx_full_flag, tx_busy_flag, tx_irq, rx_full_flag, rx_busy_flag, rx_irq;
   logic overrun_error_flag, start_error_flag, parity_error_flag, frame_error_flag, line_inv;
   logic [7:0] tx_write_data, tx_holding_reg, rx_data_reg, bit_len;
   logic [9:0] got;
   int num_errors = 0, samples_checked = 0, cycles = 0, tx_irqs = 0, rx_irqs = 0, n0, k;
   async_serial_transceiver i_dut (.clock, .sys_rst, .rc_tick, .xtal_tick, .clock_source_select, .tx_enable,
      .rx_enable_a, .rx_enable_b, .word_length_sel, .parity_enable, .parity_mode, .rx_invert, .tx_invert,
      .echo_mode, .tx_write, .tx_write_data, .rx_read, .rx_status_write, .rx_pin, .tx_pin, .tx_holding_reg,
      .tx_full_flag, .tx_busy_flag, .tx_irq, .rx_data_reg, .rx_full_flag, .rx_busy_flag, .overrun_error_flag,
      .start_error_flag, .parity_error_flag, .frame_error_flag, .rx_irq);
   remote_station i_station (.clock, .tx_line(tx_pin), .line_inv, .bit_len, .rx_line(rx_pin));
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   always @(posedge clock) begin
      #1;
      cycles++;
      rc_tick = (cycles % 2 == 0);
      xtal_tick = (cycles % 3 == 0);
      if (tx_irq === 1'b1) tx_irqs++;
      if (rx_irq === 1'b1) rx_irqs++;
      if (cycles == 40000) begin
         num_errors++;
         print_verdict();
      end
   end
   task automatic print_verdict();
      if (num_errors == 0 && samples_checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : print_verdict
   task automatic check(input logic [9:0] seen, input logic [9:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   function automatic int nb();
      return 7 + word_length_sel + parity_enable;
   endfunction : nb
   // Expected line bits: data, parity (odd when mode is 0), stop
   function automatic logic [9:0] frame(input logic [7:0] d);
      logic [9:0] f;
      f = {2'h0, d} & ((10'h001 << (7 + word_length_sel)) - 10'h001);
      if (parity_enable) f[7 + word_length_sel] = ^f[7:0] ^ ~parity_mode;
      f[nb()] = 1'b1;
      return f;
   endfunction : frame
   task automatic set_cfg(input int i);
      word_length_sel = i[0];
      parity_enable = (i > 1);
      parity_mode = (i > 3);
   endtask : set_cfg
   task automatic wt(input logic [7:0] d);
      tx_write_data = d;
      tx_write = 1'b1;
      i_station.hold(1);
      tx_write = 1'b0;
      check(tx_full_flag, 10'h001);
   endtask : wt
   task automatic tx_frame(input logic [7:0] d);
      wt(d);
      i_station.recv(nb(), got);
      check(got, frame(d));
      check(tx_busy_flag, 10'h001);
   endtask : tx_frame
   task automatic rx_frame(input logic [7:0] d, input logic [9:0] flip, input logic [2:0] errs);
      n0 = rx_irqs;
      i_station.send(frame(d) ^ flip, nb());
      check(10'(rx_irqs - n0), 10'h001);
      check(rx_full_flag, 10'h001);
      check(rx_data_reg, word_length_sel ? d : {1'b0, d[6:0]});
      check({start_error_flag, parity_error_flag, frame_error_flag}, errs);
   endtask : rx_frame
   task automatic rx_take();
      rx_read = 1'b1;
      i_station.hold(1);
      rx_read = 1'b0;
      check(rx_full_flag, 10'h000);
   endtask : rx_take
   initial begin
      {rc_tick, xtal_tick, clock_source_select, rx_enable_a, rx_enable_b, parity_enable, parity_mode} = '0;
      {rx_invert, tx_invert, echo_mode, tx_write, rx_read, rx_status_write, line_inv} = '0;
      {tx_enable, word_length_sel, sys_rst} = 3'h7;
      tx_write_data = 8'h00;
      bit_len = 8'h20;
      repeat (2) @(posedge clock);
      #1 sys_rst = 1'b0;
      // crystal ticks unused, rc ticks selected
      for (int i = 0; i < 6; i++) begin
         set_cfg(i);
         tx_frame(8'h96 + 8'h31 * i[7:0]);
      end
      n0 = tx_irqs;
      wt(8'hA1);
      // next write only once full clears
      for (k = 0; k < 20 && tx_full_flag !== 1'b0; k++) i_station.hold(1);
      wt(8'h5E);
      i_station.recv(nb(), got);
      check(got, frame(8'hA1));
      i_station.recv(nb(), got);
      check(got, frame(8'h5E));
      check(10'(tx_irqs - n0), 10'h002);
      tx_enable = 1'b0;
      i_station.hold(600);
      wt(8'h0F);
      i_station.hold(100);
      check({tx_full_flag, tx_busy_flag}, 10'h002);
      tx_enable = 1'b1;
      i_station.recv(nb(), got);
      check(got, frame(8'h0F));
      i_station.hold(40);
      clock_source_select = 1'b1;
      bit_len = 8'h30;
      for (int i = 0; i < 6; i++) begin
         set_cfg(i);
         rx_enable_a = i[0];
         rx_enable_b = ~i[0];
         rx_frame(8'h5A + 8'h27 * i[7:0], 10'h000, 3'h0);
         rx_take();
      end
      rx_frame(8'h71, 10'h001 << (nb() - 1), 3'h2);
      rx_take();
      rx_frame(8'h72, 10'h001 << nb(), 3'h1);
      rx_take();
      i_station.glitch();
      rx_frame(8'h73, 10'h000, 3'h4);
      rx_take();
      rx_frame(8'h11, 10'h000, 3'h0);
      rx_frame(8'h22, 10'h000, 3'h0);
      check(overrun_error_flag, 10'h001);
      rx_status_write = 1'b1;
      i_station.hold(1);
      rx_status_write = 1'b0;
      check(overrun_error_flag, 10'h000);
      rx_take();
      line_inv = 1'b1;
      rx_invert = 1'b1;
      tx_invert = 1'b1;
      i_station.hold(2);
      check(tx_pin, 10'h000);
      tx_frame(8'h3C);
      i_station.hold(40);
      rx_frame(8'hC3, 10'h000, 3'h0);
      rx_take();
      line_inv = 1'b0;
      rx_invert = 1'b0;
      tx_invert = 1'b0;
      echo_mode = 1'b1;
      fork
         i_station.send(frame(8'h6B), nb());
         i_station.recv(nb(), got);
      join
      check(got, frame(8'h6B));
      echo_mode = 1'b0;
      rx_take();
      {rx_enable_a, rx_enable_b} = 2'h0;
      n0 = rx_irqs;
      i_station.send(frame(8'h44), nb());
      check(10'(rx_irqs - n0), 10'h000);
      check(rx_busy_flag, 10'h000);
      print_verdict();
   end
endmodule : tb
